// ==== scip_edge.sv ====
// Rising edge detector on a synchronised slow clock level.
// Assumes the input is already in the clk_i domain.
`timescale 1ns/1ps
`default_nettype none
module scip_edge (
    // Clock and reset.
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // Level in, pulse out.
    input  wire logic lvl_i,
    output logic      rise_o
);
    logic prev;

    // Remember the previous level.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev <= 1'b0;
        end else begin
            prev <= lvl_i;
        end
    end

    // A pulse marks each rising edge of the level.
    assign rise_o = lvl_i & ~prev;
endmodule
`default_nettype wire

// ==== scip_far_end.sv ====
// Far-side model: slow crystal and slow RC oscillators, and a watchdog counter fed by the prescaler.
// Assumes clk_i is the fast system clock; each oscillator stands still low while disabled.
`timescale 1ns/1ps
`default_nettype none
module scip_far_end #(
    parameter int XT_HALF = 4,
    parameter int RC_HALF = 6
) (
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // Oscillator enables.
    input  wire logic        xtal_en_i,
    input  wire logic        rc_en_i,
    // Watchdog side.
    input  wire logic        wdt_clk_i,
    input  wire logic        wdt_clear_i,
    // Slow clocks and watchdog count.
    output logic             xtal_clk_o,
    output logic             rc_clk_o,
    output logic      [15:0] wdt_count_o
);
    logic [3:0] xt_div;
    logic [3:0] rc_div;
    logic       wdt_clk_q;

    // Crystal oscillator toggles every XT_HALF clocks and stops while disabled.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            xt_div     <= 4'h0;
            xtal_clk_o <= 1'h0;
        end else if (!xtal_en_i) begin
            xt_div     <= 4'h0;
            xtal_clk_o <= 1'h0;
        end else if (xt_div == 4'(XT_HALF - 1)) begin
            xt_div     <= 4'h0;
            xtal_clk_o <= ~xtal_clk_o;
        end else begin
            xt_div <= xt_div + 4'h1;
        end
    end

    // RC oscillator toggles every RC_HALF clocks and stops while disabled.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rc_div   <= 4'h0;
            rc_clk_o <= 1'h0;
        end else if (!rc_en_i) begin
            rc_div   <= 4'h0;
            rc_clk_o <= 1'h0;
        end else if (rc_div == 4'(RC_HALF - 1)) begin
            rc_div   <= 4'h0;
            rc_clk_o <= ~rc_clk_o;
        end else begin
            rc_div <= rc_div + 4'h1;
        end
    end

    // Watchdog counter counts rising edges of its clock and restarts on a clear pulse.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wdt_clk_q   <= 1'h0;
            wdt_count_o <= 16'h0000;
        end else begin
            wdt_clk_q <= wdt_clk_i;
            if (wdt_clear_i) begin
                wdt_count_o <= 16'h0000;
            end else if (wdt_clk_i && !wdt_clk_q) begin
                wdt_count_o <= wdt_count_o + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// ==== scip_map.svh ====
// Register map, field positions and reset values of the slow clock interval prescaler.
// Assumes inclusion by its bare name from the design files.
`ifndef SCIP_MAP_SVH
`define SCIP_MAP_SVH
`define SCIP_CTRL_OFFSET    12'h000
`define SCIP_MODE_OFFSET    12'h004
`define SCIP_STAT_OFFSET    12'h008
`define SCIP_FLAG_BIT       7
`define SCIP_IE_BIT         6
`define SCIP_SEL_HI         3
`define SCIP_SEL_LO         1
`define SCIP_CLR_BIT        0
`define SCIP_MODE_HI        2
`define SCIP_MODE_LO        0
`define SCIP_WSRC_HI        6
`define SCIP_WSRC_LO        4
`define SCIP_CTRL_RESET     8'h00
`define SCIP_CNT_ALL_ONES   17'h1FFFF
`define SCIP_CNT_ZERO       17'h00000
`define SCIP_MODE_SUB_XTAL  3'h1
`define SCIP_MODE_SUB_RC    3'h2
`define SCIP_WDT_SRC_A      3'h4
`define SCIP_WDT_SRC_B      3'h6
`define SCIP_CLKSEL_NONE    2'h0
`define SCIP_CLKSEL_XTAL    2'h1
`define SCIP_CLKSEL_RC      2'h2
`define SCIP_WDT_TAP        0
`endif

// ==== scip_pkg.sv ====
// Types of the slow clock interval prescaler.
// Assumes nothing of its surroundings.
`default_nettype none
package scip_pkg;
    typedef enum logic [2:0] {
        SCIP_MODE_MAIN    = 3'h0,
        SCIP_MODE_SUBXTAL = 3'h1,
        SCIP_MODE_SUBRC   = 3'h2
    } scip_mode_t;
    typedef logic [2:0] scip_sel_t;
endpackage
`default_nettype wire

// ==== scip_sync.sv ====
// Two flip-flop synchroniser for a group of level inputs.
// Assumes the inputs are static between changes for at least two clocks.
`timescale 1ns/1ps
`default_nettype none
module scip_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // Levels.
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta;

    // The first stage is read only by the second stage.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta <= '0;
            q_o  <= '0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end
endmodule
`default_nettype wire

// ==== scip_top.sv ====
// Slow clock interval prescaler: counter, interval flag, watchdog clock and clear, APB slave.
// Assumes slow clocks and mode levels arrive asynchronously, APB is on clk_i.
//
// Notes on behaviour
// - Count down on each divided slow clock tick.
// - Start at all ones, wrap at zero.
// - Flag on interval, not in slow stop.
// - Keep counting in stop from main modes.
// - Counter clear also clears selected watchdog.
// - Clear on slow mode to stop entry.
// - Clear when slow oscillator disabled in main.
// - Reset clears and stops the counter.
// - Main modes: stable oscillator, crystal preferred.
// - Sub modes use their own oscillator only.
// - Bit 7 flag, write 0 clears.
// - Read-modify-write read returns flag as 1.
// - Request is flag and enable.
// - Bits 5 and 4 read zero.
// - Select codes map to 2^10..2^17 periods.
// - Write 1 to bit 0 sets counter ones.
// - Watchdog clock restarts with counter clear.
// - Software clear beats coincident tap overflow.
// - Enable rise with flag set requests at once.
// - One of eight taps of 17 bits.
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "scip_map.svh"
module scip_top
    import scip_pkg::*;
#(
    parameter int CNT_W = 17
) (
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // APB slave.
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Asynchronous slow clocks and oscillator state.
    input  wire logic        slow_xtal_clk_i,
    input  wire logic        slow_rc_clk_i,
    input  wire logic        slow_xtal_osc_enable_i,
    input  wire logic        slow_rc_osc_enable_i,
    input  wire logic        slow_xtal_stable_i,
    input  wire logic        slow_rc_stable_i,
    // Stop state and read-modify-write read indication.
    input  wire logic        stop_mode_i,
    input  wire logic        rmw_read_i,
    // Outputs to the interrupt controller and the watchdog.
    output logic             interval_irq_o,
    output logic             watchdog_clk_o,
    output logic             watchdog_clear_o
);
    // ----------------------------------------------------------------
    // Synchronisers and edge detection
    // ----------------------------------------------------------------
    logic [5:0] sync_q;
    logic       xtal_s;
    logic       rc_s;
    logic       xtal_en_s;
    logic       rc_en_s;
    logic       xtal_ok_s;
    logic       rc_ok_s;
    logic       stop_s;
    logic       tick;
    logic       slow_lvl;

    scip_sync #(.WIDTH(6)) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     ({slow_xtal_clk_i, slow_rc_clk_i, slow_xtal_osc_enable_i,
                   slow_rc_osc_enable_i, slow_xtal_stable_i, slow_rc_stable_i}),
        .q_o     (sync_q)
    );

    scip_sync #(.WIDTH(1)) u_sync_stop (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .d_i     (stop_mode_i),
        .q_o     (stop_s)
    );

    assign {xtal_s, rc_s, xtal_en_s, rc_en_s, xtal_ok_s, rc_ok_s} = sync_q;

    // ----------------------------------------------------------------
    // Registers of this block
    // ----------------------------------------------------------------
    logic             interval_flag;
    logic             interval_irq_enable;
    scip_sel_t        interval_select;
    scip_mode_t       clock_mode;
    logic [2:0]       watchdog_clock_source;
    logic [CNT_W-1:0] count;
    logic             div_ph;
    logic             stop_q;
    logic             xtal_en_q;
    logic             rc_en_q;
    logic [1:0]       clk_src;

    // APB decode and write strobes.
    logic        wr_en;
    logic        rd_en;
    logic        hit_ctrl;
    logic        hit_mode;
    logic        hit_stat;
    logic        sw_clear;
    logic        hw_clear;
    logic        any_clear;
    logic        cnt_tick;
    logic        tap_fall;
    logic        tap_now;
    logic        tap_prev;
    logic        flag_set;
    logic        slow_stop;
    logic        main_mode;

    assign hit_ctrl  = paddr_i == `SCIP_CTRL_OFFSET;
    assign hit_mode  = paddr_i == `SCIP_MODE_OFFSET;
    assign hit_stat  = paddr_i == `SCIP_STAT_OFFSET;
    assign wr_en     = psel_i & penable_i & pwrite_i & pready_o;
    assign rd_en     = psel_i & ~penable_i & ~pwrite_i;
    assign main_mode = clock_mode == SCIP_MODE_MAIN;
    assign slow_stop = stop_s & ~main_mode;

    // ----------------------------------------------------------------
    // Input clock selection
    // ----------------------------------------------------------------
    // Main modes take a stable enabled oscillator, the crystal first.
    always_comb begin
        clk_src = `SCIP_CLKSEL_NONE;
        case (clock_mode)
            SCIP_MODE_SUBXTAL: begin
                clk_src = `SCIP_CLKSEL_XTAL;
            end
            SCIP_MODE_SUBRC: begin
                clk_src = `SCIP_CLKSEL_RC;
            end
            default: begin
                if (xtal_en_s && xtal_ok_s) begin
                    clk_src = `SCIP_CLKSEL_XTAL;
                end else if (rc_en_s && rc_ok_s) begin
                    clk_src = `SCIP_CLKSEL_RC;
                end
            end
        endcase
    end

    assign slow_lvl = (clk_src == `SCIP_CLKSEL_XTAL) ? xtal_s :
                      (clk_src == `SCIP_CLKSEL_RC)   ? rc_s   : 1'b0;

    scip_edge u_edge (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .lvl_i   (slow_lvl),
        .rise_o  (tick)
    );

    // ----------------------------------------------------------------
    // Clear sources
    // ----------------------------------------------------------------
    assign sw_clear = wr_en & hit_ctrl & pstrb_i[0] & pwdata_i[`SCIP_CLR_BIT];
    assign hw_clear = (stop_s & ~stop_q & ~main_mode)
                    | (main_mode & ((xtal_en_q & ~xtal_en_s) | (rc_en_q & ~rc_en_s)));
    assign any_clear = sw_clear | hw_clear;

    // Previous levels for the clear edges.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stop_q    <= 1'b0;
            xtal_en_q <= 1'b0;
            rc_en_q   <= 1'b0;
        end else begin
            stop_q    <= stop_s;
            xtal_en_q <= xtal_en_s;
            rc_en_q   <= rc_en_s;
        end
    end

    // ----------------------------------------------------------------
    // Divider and counter
    // ----------------------------------------------------------------
    // The divide-by-two phase yields one count tick per two slow edges.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_ph <= 1'b0;
        end else if (any_clear) begin
            div_ph <= 1'b0;
        end else if (tick && clk_src != `SCIP_CLKSEL_NONE) begin
            div_ph <= ~div_ph;
        end
    end

    assign cnt_tick = tick & div_ph & (clk_src != `SCIP_CLKSEL_NONE);

    // Free-running down counter with reload at zero.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count <= `SCIP_CNT_ALL_ONES;
        end else if (any_clear) begin
            count <= `SCIP_CNT_ALL_ONES;
        end else if (cnt_tick) begin
            if (count == `SCIP_CNT_ZERO) begin
                count <= `SCIP_CNT_ALL_ONES;
            end else begin
                count <= count - 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Interval detector
    // ----------------------------------------------------------------
    // Map the select code onto one counter bit.
    always_comb begin
        case (interval_select)
            3'h4:    tap_now = count[9];
            3'h0:    tap_now = count[10];
            3'h1:    tap_now = count[11];
            3'h2:    tap_now = count[12];
            3'h3:    tap_now = count[13];
            3'h5:    tap_now = count[14];
            3'h6:    tap_now = count[15];
            3'h7:    tap_now = count[16];
            default: tap_now = 1'b0;
        endcase
    end

    // Track the tap so a 0 to 1 wrap marks an elapsed interval.
    // A clear parks the history high, so reloading all ones never looks like a wrap.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tap_prev <= 1'b1;
        end else if (any_clear) begin
            tap_prev <= 1'b1;
        end else begin
            tap_prev <= tap_now;
        end
    end

    assign tap_fall = ~tap_prev & tap_now;
    assign flag_set = tap_fall & ~slow_stop & ~any_clear;

    // Interval flag: hardware set wins over a software clear.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            interval_flag <= 1'b0;
        end else if (flag_set) begin
            interval_flag <= 1'b1;
        end else if (wr_en && hit_ctrl && pstrb_i[0] && !pwdata_i[`SCIP_FLAG_BIT]) begin
            interval_flag <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    // Control, mode and watchdog source fields.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            interval_irq_enable   <= 1'b0;
            interval_select       <= 3'h0;
            clock_mode            <= SCIP_MODE_MAIN;
            watchdog_clock_source <= 3'h0;
        end else if (wr_en && pstrb_i[0]) begin
            if (hit_ctrl) begin
                interval_irq_enable <= pwdata_i[`SCIP_IE_BIT];
                interval_select     <= pwdata_i[`SCIP_SEL_HI:`SCIP_SEL_LO];
            end
            if (hit_mode) begin
                clock_mode            <= scip_mode_t'(pwdata_i[`SCIP_MODE_HI:`SCIP_MODE_LO]);
                watchdog_clock_source <= pwdata_i[`SCIP_WSRC_HI:`SCIP_WSRC_LO];
            end
        end
    end

    // ----------------------------------------------------------------
    // APB answer and outputs
    // ----------------------------------------------------------------
    // No wait state: pready rises in the first cycle of the access phase.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h00000000;
        end else begin
            pready_o  <= psel_i & ~penable_i;
            pslverr_o <= psel_i & ~penable_i & ~(hit_ctrl | hit_mode | hit_stat);
            if (rd_en) begin
                prdata_o <= 32'h00000000;
                if (hit_ctrl) begin
                    prdata_o[7:0] <= {interval_flag | rmw_read_i, interval_irq_enable,
                                      2'b00, interval_select, 1'b0};
                end else if (hit_mode) begin
                    prdata_o[7:0] <= {1'b0, watchdog_clock_source, 1'b0, clock_mode};
                end else if (hit_stat) begin
                    prdata_o[CNT_W-1:0] <= count;
                end
            end
        end
    end

    // Interrupt, watchdog clock and watchdog clear.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            interval_irq_o   <= 1'b0;
            watchdog_clk_o   <= 1'b0;
            watchdog_clear_o <= 1'b0;
        end else begin
            interval_irq_o   <= (interval_flag | flag_set) & interval_irq_enable;
            watchdog_clk_o   <= any_clear ? 1'b0 : ~count[`SCIP_WDT_TAP];
            watchdog_clear_o <= any_clear & (watchdog_clock_source == `SCIP_WDT_SRC_A ||
                                             watchdog_clock_source == `SCIP_WDT_SRC_B);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    clear_ones_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        sw_clear |=> count == `SCIP_CNT_ALL_ONES)
        else $error("counter not all ones after clear");
    wrap_reload_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (cnt_tick && !any_clear && count == `SCIP_CNT_ZERO) |=> count == `SCIP_CNT_ALL_ONES)
        else $error("counter did not reload at zero");
    count_step_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (cnt_tick && !any_clear && count != `SCIP_CNT_ZERO) |=> count == $past(count) - 1'b1)
        else $error("counter did not step down");
    irq_follow_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (interval_flag && interval_irq_enable) |=> interval_irq_o)
        else $error("request missing with flag and enable");
    no_flag_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (tap_fall && sw_clear && !interval_flag) |=> !interval_flag)
        else $error("flag set on coincident clear");
    slow_stop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (slow_stop && !interval_flag && !(wr_en && hit_ctrl)) |=> !interval_flag)
        else $error("flag set in slow stop");
    wdt_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (any_clear && watchdog_clock_source == `SCIP_WDT_SRC_A) |=> watchdog_clear_o)
        else $error("watchdog clear missing");
    hw_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (stop_s && !stop_q && !main_mode) |=> count == `SCIP_CNT_ALL_ONES && !div_ph)
        else $error("stop entry did not clear counter");
    wdt_phase_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        any_clear |=> !watchdog_clk_o)
        else $error("watchdog clock not restarted");
endmodule
`default_nettype wire

// ==== slow_clock_interval_prescaler_tb.sv ====
// Self-checking testbench of the slow clock interval prescaler.
// Assumes scip_pkg, scip_top and scip_far_end are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "scip_map.svh"
module slow_clock_interval_prescaler_tb;
    typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;} scip_row_t;
    typedef struct {logic [31:0] m; logic xe; logic xs; logic re; logic rs; logic [31:0] r;} scip_meas_t;
    logic        clk_i, rst_n_i, psel, penable, pwrite, pready, pslverr, rmw, stop, er;
    logic        xt_en, xt_st, rc_en, rc_st, xt_clk, rc_clk, irq, wclk, counter_clear;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, d;
    logic [15:0] wdt_cnt;
    logic [2:0]  srcs [3] = '{3'h0, 3'h4, 3'h6};
    int          errors = 0, checked = 0, cycles = 0, counter_clear_cnt = 0, n;
    // Register rows: address, write data, expected read data, expected error.
    scip_row_t rows [12] = '{
        '{`SCIP_CTRL_OFFSET, 32'h000000B1, 32'h00000000, 1'h0}, '{`SCIP_CTRL_OFFSET, 32'h000000B3, 32'h00000002, 1'h0},
        '{`SCIP_CTRL_OFFSET, 32'h000000B5, 32'h00000004, 1'h0}, '{`SCIP_CTRL_OFFSET, 32'h000000B7, 32'h00000006, 1'h0},
        '{`SCIP_CTRL_OFFSET, 32'h000000B9, 32'h00000008, 1'h0}, '{`SCIP_CTRL_OFFSET, 32'h000000BB, 32'h0000000A, 1'h0},
        '{`SCIP_CTRL_OFFSET, 32'h000000BD, 32'h0000000C, 1'h0}, '{`SCIP_CTRL_OFFSET, 32'h000000BF, 32'h0000000E, 1'h0},
        '{`SCIP_CTRL_OFFSET, 32'h00000071, 32'h00000040, 1'h0}, '{`SCIP_STAT_OFFSET, 32'h00000000, 32'h0001FFFF, 1'h0},
        '{`SCIP_MODE_OFFSET, 32'h00000000, 32'h00000000, 1'h0}, '{12'h00C, 32'hFFFFFFFF, 32'h00000000, 1'h1}};
    // Clock source rows: mode, enables and stability, expected ticks in one window.
    scip_meas_t ms [5] = '{'{32'h0, 1'h0, 1'h0, 1'h1, 1'h1, 32'd20}, '{32'h0, 1'h1, 1'h0, 1'h1, 1'h1, 32'd20},
        '{32'h0, 1'h1, 1'h1, 1'h1, 1'h1, 32'd30}, '{32'h2, 1'h1, 1'h1, 1'h1, 1'h1, 32'd20},
        '{32'h1, 1'h1, 1'h1, 1'h1, 1'h1, 32'd30}};

    scip_top DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .slow_xtal_clk_i(xt_clk), .slow_rc_clk_i(rc_clk), .slow_xtal_osc_enable_i(xt_en),
        .slow_rc_osc_enable_i(rc_en), .slow_xtal_stable_i(xt_st), .slow_rc_stable_i(rc_st), .stop_mode_i(stop),
        .rmw_read_i(rmw), .interval_irq_o(irq), .watchdog_clk_o(wclk), .watchdog_clear_o(counter_clear));
    scip_far_end far (.clk_i(clk_i), .rst_n_i(rst_n_i), .xtal_en_i(xt_en), .rc_en_i(rc_en), .wdt_clk_i(wclk),
        .wdt_clear_i(counter_clear), .xtal_clk_o(xt_clk), .rc_clk_o(rc_clk), .wdt_count_o(wdt_cnt));

    // Clock of 4 ns.
    initial begin
        clk_i = 1'h0;
        forever #2 clk_i = ~clk_i;
    end

    // Cycle counter for the hang limit, and count of watchdog clear pulses.
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (counter_clear === 1'h1) counter_clear_cnt <= counter_clear_cnt + 1;
        if (cycles == 85000) begin
            errors = errors + 1;
            end_of_test();
        end
    end

    // Prints the counts and the verdict, then stops.
    task automatic end_of_test();
        $display("Counts: checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // Compares a seen value with the expected one.
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; read data and error land in rd and er.
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
        int k;
        @(posedge clk_i);
        psel    <= 1'h1;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= wd;
        @(posedge clk_i);
        penable <= 1'h1;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (pready !== 1'h1 && k < 20);
        if (k >= 20) chk("pready wait", 32'h0, 32'h1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'h0;
        penable <= 1'h0;
    endtask

    // Waits until the request rises or the limit runs out; n holds the clocks waited.
    task automatic wait_irq();
        n = 0;
        while (irq !== 1'h1 && n < 40000) begin
            @(posedge clk_i);
            n++;
        end
    endtask

    // Counter ticks between two status reads 480 clocks apart.
    task automatic rate();
        logic [31:0] s;
        apb(`SCIP_STAT_OFFSET, 1'h0, 32'h0);
        s = rd;
        repeat (480) @(posedge clk_i);
        apb(`SCIP_STAT_OFFSET, 1'h0, 32'h0);
        d = s - rd;
    endtask

    // Main sequence: reset, register rows, clock sources, clears, intervals.
    initial begin
        {rst_n_i, psel, penable, pwrite, rmw, stop, xt_en, xt_st, rc_en, rc_st} = 10'h000;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1'h1;
        repeat (3) @(posedge clk_i);
        chk("irq at reset", {31'h0, irq}, 32'h0);
        apb(`SCIP_STAT_OFFSET, 1'h0, 32'h0);
        chk("count at reset", rd, 32'h0001FFFF);
        $display("Test reset done");
        for (int i = 0; i < 12; i++) begin
            apb(rows[i].a, 1'h1, rows[i].d);
            apb(rows[i].a, 1'h0, 32'h0);
            chk("register read", rd, rows[i].x);
            chk("register error", {31'h0, er}, {31'h0, rows[i].e});
        end
        $display("Test register rows done");
        for (int i = 0; i < 5; i++) begin
            {xt_en, xt_st, rc_en, rc_st} <= {ms[i].xe, ms[i].xs, ms[i].re, ms[i].rs};
            apb(`SCIP_MODE_OFFSET, 1'h1, ms[i].m);
            repeat (40) @(posedge clk_i);
            rate();
            chk("tick rate", {31'h0, d >= ms[i].r - 32'h1 && d <= ms[i].r + 32'h1}, 32'h1);
        end
        $display("Test clock sources done");
        apb(`SCIP_MODE_OFFSET, 1'h1, 32'h0);
        repeat (200) @(posedge clk_i);
        {xt_en, xt_st} <= 2'h0;
        repeat (8) @(posedge clk_i);
        apb(`SCIP_STAT_OFFSET, 1'h0, 32'h0);
        chk("clear on osc off", {31'h0, rd >= 32'h0001FFFE}, 32'h1);
        {xt_en, xt_st} <= 2'h3;
        apb(`SCIP_MODE_OFFSET, 1'h1, 32'h1);
        repeat (200) @(posedge clk_i);
        stop <= 1'h1;
        repeat (8) @(posedge clk_i);
        apb(`SCIP_STAT_OFFSET, 1'h0, 32'h0);
        chk("clear on stop", {31'h0, rd >= 32'h0001FFFE}, 32'h1);
        apb(`SCIP_CTRL_OFFSET, 1'h1, 32'h49);
        repeat (16700) @(posedge clk_i);
        apb(`SCIP_CTRL_OFFSET, 1'h0, 32'h0);
        chk("no flag in slow stop", rd, 32'h48);
        chk("no irq in slow stop", {31'h0, irq}, 32'h0);
        stop <= 1'h0;
        $display("Test hardware clears done");
        for (int i = 0; i < 3; i++) begin
            apb(`SCIP_MODE_OFFSET, 1'h1, {25'h0, srcs[i], 4'h1});
            n = counter_clear_cnt;
            apb(`SCIP_CTRL_OFFSET, 1'h1, 32'h09);
            repeat (3) @(posedge clk_i);
            chk("watchdog clears", counter_clear_cnt - n, {31'h0, srcs[i] != 3'h0});
            if (srcs[i] != 3'h0) chk("watchdog restart", {31'h0, wdt_cnt <= 16'h1}, 32'h1);
        end
        $display("Test watchdog done");
        apb(`SCIP_MODE_OFFSET, 1'h1, 32'h0);
        apb(`SCIP_CTRL_OFFSET, 1'h1, 32'h48);
        apb(`SCIP_CTRL_OFFSET, 1'h1, 32'h49);
        wait_irq();
        chk("interval of code 4", {31'h0, n >= 16376 && n <= 16420}, 32'h1);
        apb(`SCIP_CTRL_OFFSET, 1'h0, 32'h0);
        chk("flag set", rd, 32'hC8);
        apb(`SCIP_CTRL_OFFSET, 1'h1, 32'h48);
        repeat (2) @(posedge clk_i);
        chk("irq after flag clear", {31'h0, irq}, 32'h0);
        rmw <= 1'h1;
        apb(`SCIP_CTRL_OFFSET, 1'h0, 32'h0);
        rmw <= 1'h0;
        chk("rmw read", rd, 32'hC8);
        stop <= 1'h1;
        apb(`SCIP_CTRL_OFFSET, 1'h1, 32'h01);
        repeat (32690) @(posedge clk_i);
        apb(`SCIP_CTRL_OFFSET, 1'h0, 32'h0);
        chk("no flag early", rd, 32'h00);
        repeat (120) @(posedge clk_i);
        apb(`SCIP_CTRL_OFFSET, 1'h0, 32'h0);
        chk("flag in main stop", rd, 32'h80);
        chk("irq masked", {31'h0, irq}, 32'h0);
        apb(`SCIP_CTRL_OFFSET, 1'h1, 32'hC0);
        repeat (2) @(posedge clk_i);
        chk("irq on enable", {31'h0, irq}, 32'h1);
        stop <= 1'h0;
        $display("Test intervals done");
        end_of_test();
    end
endmodule
`default_nettype wire
